// ---- sfa_alloc.sv ----
// option interface configuration, i/o function allocation and link supervision
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
//
// Contract
// [R1] interface enabled only when enable setting is 1, default 0, applied at restart
// [R2] response timeout 100 to 10000 ms, default 100, applied at restart
// [R3] latch 1 on input 4, latch 2 on input 5, homing anywhere; nc latch alarms
// [R4] serial control outputs 1-3 allowed on outputs 1, 2, 4, 5, 6 only
// [R5] drive-outputs word bits 0-2 drive serial control outputs 1-3
// [R6] output 5 and 6 selections, 24 bits, defaults 460551 and 394758, at restart
// [R7] forbidden input functions raise alarm 33.2 or 33.3 while enabled
// [R8] run or latch functions allocated in some modes only raise alarm 33.8
// [R9] enabled interface disables block programming, gear and pulse command
// [R10] configurer sets absolute interface to 0, no pulse regeneration output
// [R11] configurer clears enable before test run, fft or jog
// [R12] expansion connector carries the serial link from the option unit
// [R13] one communication error latches warning aah with no time limit
// [R14] missing response within timeout counts as a communication error
module sfa_alloc #(
   parameter int TICK_CYCLES = sfa_pkg::MS_CYCLES
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic [sfa_pkg::AW-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_stb_i,
   input wire logic rd_stb_i,
   output logic [31:0] rd_data_o,
   input wire logic pwr_restart_i,
   input wire logic [1:0] control_mode_i,
   input wire logic [sfa_pkg::IN_N-1:0] multi_function_inputs_i,
   input wire logic [sfa_pkg::OUT_N-1:0] gen_out_i,
   input wire logic link_valid_i,
   input wire logic [2:0] link_word_i,
   input wire logic link_err_i,
   output logic [sfa_pkg::OUT_N-1:0] multi_function_outputs_o,
   output logic latch_input_1_o,
   output logic latch_input_2_o,
   output logic homing_o,
   output logic iface_en_o,
   output logic gear_enable_o,
   output logic block_prog_enable_o,
   output logic pulse_cmd_enable_o,
   output logic warn_comm_o,
   output logic alarm_33_0_o,
   output logic alarm_33_2_o,
   output logic alarm_33_3_o,
   output logic alarm_33_8_o,
   output logic irq_o
);
   import sfa_pkg::*;

   // the ms prescaler is 16 bits wide, so longer ticks cannot be counted
   if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_bad_tick
      $error("TICK_CYCLES out of range");
   end

   typedef struct packed {
      logic en_p;
      logic en_a;
      logic [13:0] tmo_p;
      logic [13:0] tmo_a;
      logic [IN_N-1:0][SEL_W-1:0] isel_p;
      logic [IN_N-1:0][SEL_W-1:0] isel_a;
      logic [OUT_N-1:0][SEL_W-1:0] osel_p;
      logic [OUT_N-1:0][SEL_W-1:0] osel_a;
      logic [2:0] dout;
      logic [ST_W-1:0] st;
      logic [ST_W-1:0] ien;
      logic [15:0] tick;
      logic [13:0] ms;
      logic [31:0] rdata;
      logic [OUT_N-1:0] so;
      logic l1;
      logic l2;
      logic home;
      logic gear;
      logic [3:0] alm;
      logic irq;
   } sfa_state_t;

   sfa_state_t q;
   sfa_state_t d;

   ////////////////////////////////////////////////////////////////////////////
   // allocation decode, checked over every control mode

   logic [1:0] msel;
   logic [IN_N-1:0][MODE_N-1:0] run_m, l1_m, l2_m, fb_no, fb_nc, l_bad;
   logic [IN_N-1:0][FN_W-1:0] in_code;
   logic [OUT_N-1:0][FN_W-1:0] out_code;

   // an unused mode code falls back to position control
   assign msel = (control_mode_i == 2'h3) ? 2'h0 : control_mode_i;

   function automatic logic is_forbid(input logic [FN_W-1:0] c);
      logic hit;
      hit = 1'b0;
      for (int k = 0; k < 11; k++) begin
         hit = hit | (c == FN_FORBID[k]);
      end
      return hit;
   endfunction

   for (genvar i = 0; i < IN_N; i++) begin : g_in
      assign in_code[i] = q.isel_a[i][{msel, 3'h0} +: FN_W];
      for (genvar j = 0; j < MODE_N; j++) begin : g_mode
         logic [FN_W-1:0] c;
         assign c = q.isel_a[i][j*FN_W +: FN_W];
         assign run_m[i][j] = (c == FN_RUN);
         assign l1_m[i][j] = (c == FN_LATCH1);
         assign l2_m[i][j] = (c == FN_LATCH2);
         assign fb_no[i][j] = is_forbid(c); // R7
         assign fb_nc[i][j] = ((c & FN_NC) != 8'h00) && is_forbid(c & ~FN_NC); // R7
         // a latch on the wrong input is not accepted and flagged like nc
         assign l_bad[i][j] = (c == (FN_LATCH1 | FN_NC)) || (c == (FN_LATCH2 | FN_NC)) ||
                              (l1_m[i][j] && i != LATCH1_PIN) || (l2_m[i][j] && i != LATCH2_PIN); // R3
      end
   end

   for (genvar o = 0; o < OUT_N; o++) begin : g_out
      assign out_code[o] = q.osel_a[o][{msel, 3'h0} +: FN_W];
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic [31:0] rv;
      logic [MODE_N-1:0] run_any, l1_any, l2_any;
      logic [3:0] alm;
      logic tmo_ev;
      logic err_ev;
      logic [ST_W-1:0] clr;
      logic [ST_W-1:0] set;
      rv = 32'h0;
      run_any = '0;
      l1_any = '0;
      l2_any = '0;
      alm = 4'h0;
      tmo_ev = 1'b0;
      err_ev = 1'b0;
      clr = '0;
      set = '0;
      d = q;
      d.rdata = 32'h0;
      for (int i = 0; i < IN_N; i++) begin
         run_any = run_any | run_m[i];
         l1_any = l1_any | l1_m[i];
         l2_any = l2_any | l2_m[i];
         alm[0] = alm[0] | (|l_bad[i]); // R3
         alm[1] = alm[1] | (|fb_no[i]); // R7
         alm[2] = alm[2] | (|fb_nc[i]); // R7
      end
      alm[3] = (run_any != 3'h0 && run_any != 3'h7) || (l1_any != 3'h0 && l1_any != 3'h7) ||
               (l2_any != 3'h0 && l2_any != 3'h7); // R8
      if (!q.en_a) begin
         alm = 4'h0;
      end
      unique case (addr_i)
         OFF_CFG: rv = {23'h0, q.en_a, 7'h0, q.en_p};
         OFF_TMO: rv = {2'h0, q.tmo_a, 2'h0, q.tmo_p};
         OFF_STAT: rv = {29'h0, q.st};
         OFF_IEN: rv = {29'h0, q.ien};
         OFF_ALM: rv = {28'h0, q.alm};
         OFF_DOUT: rv = {29'h0, q.dout};
         default: rv = 32'h0;
      endcase
      for (int i = 0; i < IN_N; i++) begin
         if (addr_i == AW'(OFF_ISEL + 4 * i)) begin
            rv = {8'h0, q.isel_p[i]};
         end
      end
      for (int o = 0; o < OUT_N; o++) begin
         if (addr_i == AW'(OFF_OSEL + 4 * o)) begin
            rv = {8'h0, q.osel_p[o]};
         end
      end
      if (ce_i) begin
         if (rd_stb_i) begin
            d.rdata = rv;
         end
         if (wr_stb_i) begin
            if (addr_i == OFF_CFG) begin
               d.en_p = wdata_i[0]; // R1
            end
            // out of range timeouts are ignored, the old value stays
            if (addr_i == OFF_TMO && wdata_i >= 32'(TMO_MIN_MS) && wdata_i <= 32'(TMO_MAX_MS)) begin
               d.tmo_p = wdata_i[13:0]; // R2
            end
            if (addr_i == OFF_IEN) begin
               d.ien = wdata_i[ST_W-1:0];
            end
            if (addr_i == OFF_CLR) begin
               clr = wdata_i[ST_W-1:0];
            end
            for (int i = 0; i < IN_N; i++) begin
               if (addr_i == AW'(OFF_ISEL + 4 * i)) begin
                  d.isel_p[i] = wdata_i[SEL_W-1:0];
               end
            end
            for (int o = 0; o < OUT_N; o++) begin
               if (addr_i == AW'(OFF_OSEL + 4 * o)) begin
                  d.osel_p[o] = wdata_i[SEL_W-1:0]; // R6
               end
            end
         end
         if (pwr_restart_i) begin
            // settings only take hold at a control power restart
            d.en_a = q.en_p; // R1
            d.tmo_a = q.tmo_p; // R2
            d.isel_a = q.isel_p;
            d.osel_a = q.osel_p; // R6
            d.tick = 16'h0;
            d.ms = 14'h0;
         end else if (q.en_a) begin
            err_ev = link_err_i; // R13
            if (link_valid_i) begin
               d.dout = link_word_i; // R5 R12
               d.tick = 16'h0;
               d.ms = 14'h0;
            end else if (q.tick == 16'(TICK_CYCLES - 1)) begin
               d.tick = 16'h0;
               if (q.ms + 14'h0001 >= q.tmo_a) begin
                  d.ms = 14'h0;
                  tmo_ev = 1'b1; // R14
               end else begin
                  d.ms = q.ms + 14'h0001; // R2
               end
            end else begin
               d.tick = q.tick + 16'h0001;
            end
         end
         set[ST_WARN] = err_ev | tmo_ev; // R13 R14
         set[ST_TMO] = tmo_ev;
         set[ST_ALM] = (alm & ~q.alm) != 4'h0;
         d.st = (q.st & ~clr) | set; // R13
         d.alm = alm;
         d.l1 = q.en_a && in_code[LATCH1_PIN] == FN_LATCH1 && multi_function_inputs_i[LATCH1_PIN]; // R3
         d.l2 = q.en_a && in_code[LATCH2_PIN] == FN_LATCH2 && multi_function_inputs_i[LATCH2_PIN]; // R3
         d.home = 1'b0;
         for (int i = 0; i < IN_N; i++) begin
            if (q.en_a && in_code[i] == FN_HOME_NO && multi_function_inputs_i[i]) begin
               d.home = 1'b1; // R3
            end
            if (q.en_a && in_code[i] == FN_HOME_NC && !multi_function_inputs_i[i]) begin
               d.home = 1'b1; // R3
            end
         end
         for (int o = 0; o < OUT_N; o++) begin
            d.so[o] = gen_out_i[o];
            // the alarm output can never carry a serial control bit
            if (q.en_a && o != ALARM_OUT && out_code[o] >= FN_SCTRL1 && out_code[o] <= FN_SCTRL3) begin
               d.so[o] = q.dout[out_code[o][1:0]]; // R4 R5
            end
         end
         d.gear = !q.en_a; // R9
         d.irq = ((d.st & d.ien) != '0);
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         q <= '0;
         q.en_p <= RST_EN;
         q.en_a <= RST_EN;
         q.tmo_p <= RST_TMO_MS;
         q.tmo_a <= RST_TMO_MS;
         q.isel_p <= {IN_N{RST_SEL}};
         q.isel_a <= {IN_N{RST_SEL}};
         q.osel_p <= {RST_OUT6, RST_OUT5, {OUT_N-2{RST_SEL}}}; // R6
         q.osel_a <= {RST_OUT6, RST_OUT5, {OUT_N-2{RST_SEL}}};
         q.st <= RST_ST;
         q.gear <= 1'b1;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign rd_data_o = q.rdata;
   assign multi_function_outputs_o = q.so;
   assign latch_input_1_o = q.l1;
   assign latch_input_2_o = q.l2;
   assign homing_o = q.home;
   assign iface_en_o = q.en_a;
   assign gear_enable_o = q.gear;
   assign block_prog_enable_o = q.gear;
   assign pulse_cmd_enable_o = q.gear;
   assign warn_comm_o = q.st[ST_WARN];
   assign alarm_33_0_o = q.alm[0];
   assign alarm_33_2_o = q.alm[1];
   assign alarm_33_3_o = q.alm[2];
   assign alarm_33_8_o = q.alm[3];
   assign irq_o = q.irq;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_word;
      ce_i && q.en_a && !pwr_restart_i && link_valid_i;
   endsequence
   sequence s_warn_kept;
      q.st[ST_WARN] && !(ce_i && wr_stb_i && addr_i == OFF_CLR && wdata_i[ST_WARN]);
   endsequence

   a_en_applied: assert property (!(ce_i && pwr_restart_i) |=> $stable(iface_en_o)) // R1
      else $error("enable changed without restart");
   a_tmo_fires: assert property (ce_i && q.en_a && !pwr_restart_i && !link_valid_i &&
      q.tick == 16'(TICK_CYCLES - 1) && q.ms + 14'h0001 >= q.tmo_a |=> q.st[ST_TMO] && q.ms == 14'h0) // R14
      else $error("timeout not flagged");
   a_latch_pin: assert property ($past(ce_i) && latch_input_1_o |->
      $past(multi_function_inputs_i[LATCH1_PIN]) && $past(q.en_a)) // R3
      else $error("latch 1 from wrong input");
   a_alarm_pin: assert property ($past(ce_i) |-> multi_function_outputs_o[ALARM_OUT] ==
      $past(gen_out_i[ALARM_OUT])) // R4
      else $error("serial bit on alarm output");
   a_word_taken: assert property (s_word |=> q.dout == $past(link_word_i)) // R5
      else $error("drive outputs word lost");
   a_out5_reset: assert property ($fell(sys_rst_i) |-> q.osel_p[4] == RST_OUT5 && q.osel_p[5] == RST_OUT6) // R6
      else $error("output selection defaults wrong");
   a_forbid_alm: assert property ((alarm_33_2_o || alarm_33_3_o || alarm_33_8_o) |-> $past(q.en_a)) // R7 R8
      else $error("allocation alarm while disabled");
   a_gear_off: assert property (iface_en_o && $past(ce_i) && $past(iface_en_o) |->
      !gear_enable_o && !block_prog_enable_o && !pulse_cmd_enable_o) // R9
      else $error("gear left on while enabled");
   a_warn_sticky: assert property (s_warn_kept |=> warn_comm_o) // R13
      else $error("warning dropped");
   a_irq_level: assert property ($past(ce_i) |-> irq_o == ((q.st & q.ien) != '0))
      else $error("interrupt level wrong");
endmodule

// ---- sfa_alloc_test.sv ----
// self-checking bench for the option interface allocation block
`timescale 1ns/1ps
module sfa_alloc_test;
   import sfa_pkg::*;
   logic clock_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rst_p = 1'b0;
   logic ce = 1'b1;
   logic [1:0] mode = 2'h1;
   logic [9:0] mfi = 10'h000;
   logic [5:0] gen = 6'h00;
   logic lv, le;
   logic [2:0] lw, w;
   logic [31:0] rdat;
   logic [5:0] mfo;
   logic l1, l2, hm, ien, gen_en, bp_en, pc_en, warn, a0, a2, a3, a8, irq;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   always #25 clock_i = ~clock_i;
   ////////////////////////////////////////////////////////////////////////////////
   // a short ms tick keeps the 100 ms timeout at 400 cycles
   sfa_alloc #(.TICK_CYCLES(4)) sfa_alloc_i (
      .clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .addr_i(addr), .wdata_i(wdata),
      .wr_stb_i(wr), .rd_stb_i(rd), .rd_data_o(rdat), .pwr_restart_i(rst_p), .control_mode_i(mode),
      .multi_function_inputs_i(mfi), .gen_out_i(gen), .link_valid_i(lv), .link_word_i(lw),
      .link_err_i(le), .multi_function_outputs_o(mfo), .latch_input_1_o(l1), .latch_input_2_o(l2),
      .homing_o(hm), .iface_en_o(ien), .gear_enable_o(gen_en), .block_prog_enable_o(bp_en),
      .pulse_cmd_enable_o(pc_en), .warn_comm_o(warn), .alarm_33_0_o(a0), .alarm_33_2_o(a2),
      .alarm_33_3_o(a3), .alarm_33_8_o(a8), .irq_o(irq)
   );
   sfa_ctrl_model ctrl_i (.clock_i(clock_i), .link_valid_o(lv), .link_word_o(lw), .link_err_o(le));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock_i);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe edge
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input string nm);
      @(posedge clock_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock_i);
      rd <= 1'b0;
      #1;
      chk(nm, e, rdat);
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   task automatic pwr_restart();
      @(posedge clock_i);
      rst_p <= 1'b1;
      @(posedge clock_i);
      rst_p <= 1'b0;
      wait_cyc(4);
   endtask
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      wait_cyc(1);
      chk("enables", 32'h7, {29'h0, gen_en, bp_en, pc_en});
      rd_reg(OFF_CFG, 32'h0, "cfg");
      rd_reg(OFF_TMO, 32'h0064_0064, "tmo");
      rd_reg(OFF_OSEL + 8'h10, 32'h0007_0707, "osel5");
      rd_reg(OFF_OSEL + 8'h14, 32'h0006_0606, "osel6");
      rd_reg(8'h30, 32'h0, "unmapped");
      ctrl_i.send(3'h7);
      rd_reg(OFF_DOUT, 32'h0, "dout_off");
      wr_reg(OFF_TMO, 32'd99);
      wr_reg(OFF_TMO, 32'd10001);
      rd_reg(OFF_TMO, 32'h0064_0064, "tmo_range");
      wr_reg(OFF_TMO, 32'd10000);
      rd_reg(OFF_TMO, 32'h0064_2710, "tmo_max");
      wr_reg(OFF_TMO, 32'd100);
      wr_reg(OFF_CFG, 32'h1);
      rd_reg(OFF_CFG, 32'h1, "cfg_pend");
      chk("iface_en", 32'h0, {31'h0, ien});
      // output 3 is the alarm output and must refuse a serial code
      wr_reg(OFF_OSEL, 32'h20_2020);
      wr_reg(OFF_OSEL + 8'h04, 32'h21_2121);
      wr_reg(OFF_OSEL + 8'h08, 32'h20_2020);
      wr_reg(OFF_OSEL + 8'h0c, 32'h22_2222);
      wr_reg(OFF_ISEL, 32'h22_2222);
      wr_reg(OFF_ISEL + 8'h0c, 32'h20_2020);
      wr_reg(OFF_ISEL + 8'h10, 32'h21_2121);
      pwr_restart();
      chk("iface_en", 32'h1, {31'h0, ien});
      chk("enables", 32'h0, {29'h0, gen_en, bp_en, pc_en});
      rd_reg(OFF_CFG, 32'h101, "cfg_act");
      rd_reg(OFF_ALM, 32'h0, "alm_clean");
      // normal levels differ from the serial bits, so a wrong source shows
      @(posedge clock_i);
      gen <= 6'h24;
      for (int k = 0; k < 8; k++) begin
         w = 3'(k);
         ctrl_i.send(w);
         wait_cyc(2);
         chk("mfo", {26'h0, 1'b1, 1'b0, w[2], 1'b1, w[1:0]}, {26'h0, mfo});
      end
      rd_reg(OFF_DOUT, 32'h7, "dout");
      @(posedge clock_i);
      mfi <= 10'h019;
      wait_cyc(3);
      chk("latch_home", 32'h7, {29'h0, l1, l2, hm});
      wr_reg(OFF_ISEL + 8'h04, 32'h00_8202);
      wr_reg(OFF_ISEL + 8'h14, 32'h00_0001);
      wr_reg(OFF_ISEL + 8'h18, 32'h20_2020);
      wr_reg(OFF_OSEL + 8'h10, 32'h00_0022);
      pwr_restart();
      rd_reg(OFF_ALM, 32'hf, "alm");
      chk("alm_o", 32'hf, {28'h0, a8, a3, a2, a0});
      // output 5 carries a serial code in position mode only; code 3 falls back to it
      chk("out5_mode1", 32'h0, {31'h0, mfo[4]});
      @(posedge clock_i);
      mode <= 2'h3;
      wait_cyc(2);
      chk("out5_mode3", 32'h1, {31'h0, mfo[4]});
      wr_reg(OFF_IEN, 32'h1);
      ctrl_i.send(3'h0);
      wr_reg(OFF_CLR, 32'h7);
      rd_reg(OFF_STAT, 32'h0, "stat_clr");
      chk("irq", 32'h0, {31'h0, irq});
      ctrl_i.comm_err();
      wait_cyc(2);
      chk("warn_irq", 32'h3, {30'h0, warn, irq});
      rd_reg(OFF_STAT, 32'h1, "stat_err");
      wr_reg(OFF_CLR, 32'h1);
      wait_cyc(2);
      chk("warn_clr", 32'h0, {30'h0, warn, irq});
      wr_reg(OFF_IEN, 32'h0);
      ctrl_i.comm_err();
      wait_cyc(2);
      chk("masked", 32'h2, {30'h0, warn, irq});
      // a low clock enable freezes every register except the read data, which clears; writes included
      @(posedge clock_i);
      ce <= 1'b0;
      wr_reg(OFF_IEN, 32'h7);
      ce <= 1'b1;
      rd_reg(OFF_IEN, 32'h0, "ien_frozen");
      chk("warn_frozen", 32'h2, {30'h0, warn, irq});
      // silence from the controller: nothing before 100 ms, error after it
      ctrl_i.send(3'h0);
      wr_reg(OFF_CLR, 32'h7);
      wait_cyc(360);
      rd_reg(OFF_STAT, 32'h0, "stat_early");
      wait_cyc(60);
      rd_reg(OFF_STAT, 32'h3, "stat_tmo");
      // the configurer turns the interface off before service functions
      wr_reg(OFF_CFG, 32'h0);
      pwr_restart();
      chk("iface_off", 32'h0, {31'h0, ien});
      chk("enables_off", 32'h7, {29'h0, gen_en, bp_en, pc_en});
      chk("alm_off", 32'h0, {28'h0, a8, a3, a2, a0});
      stop_test();
   end
endmodule

// ---- sfa_ctrl_model.sv ----
// motion controller model: sends drive-outputs words and link errors
`timescale 1ns/1ps
module sfa_ctrl_model (
   input wire logic clock_i,
   output logic link_valid_o,
   output logic [2:0] link_word_o,
   output logic link_err_o
);
   initial begin
      link_valid_o = 1'b0;
      link_word_o = 3'h5;
      link_err_o = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // one word per call, bit n commands serial control output n+1
   task automatic send(input logic [2:0] w);
      @(posedge clock_i);
      link_valid_o <= 1'b1;
      link_word_o <= w;
      @(posedge clock_i);
      link_valid_o <= 1'b0;
      // word not held after valid, so stale data cannot pass for fresh
      link_word_o <= ~w;
   endtask
   task automatic comm_err();
      @(posedge clock_i);
      link_err_o <= 1'b1;
      @(posedge clock_i);
      link_err_o <= 1'b0;
   endtask
endmodule

// ---- sfa_pkg.sv ----
// constants for the option interface function allocation block
package sfa_pkg;
   localparam int IN_N = 10;
   localparam int OUT_N = 6;
   localparam int MODE_N = 3;
   localparam int SEL_W = 24;
   localparam int FN_W = 8;
   localparam int AW = 8;
   localparam int ST_W = 3;
   localparam int ST_WARN = 0;
   localparam int ST_TMO = 1;
   localparam int ST_ALM = 2;
   localparam logic [7:0] OFF_CFG = 8'h00;
   localparam logic [7:0] OFF_TMO = 8'h04;
   localparam logic [7:0] OFF_STAT = 8'h08;
   localparam logic [7:0] OFF_CLR = 8'h0c;
   localparam logic [7:0] OFF_IEN = 8'h10;
   localparam logic [7:0] OFF_ALM = 8'h14;
   localparam logic [7:0] OFF_DOUT = 8'h18;
   localparam logic [7:0] OFF_ISEL = 8'h40;
   localparam logic [7:0] OFF_OSEL = 8'h80;
   localparam logic RST_EN = 1'b0;
   localparam logic [13:0] TMO_MIN_MS = 14'h0064;
   localparam logic [13:0] TMO_MAX_MS = 14'h2710;
   localparam logic [13:0] RST_TMO_MS = 14'h0064;
   localparam logic [23:0] RST_OUT5 = 24'h070707;
   localparam logic [23:0] RST_OUT6 = 24'h060606;
   localparam logic [23:0] RST_SEL = 24'h000000;
   localparam logic [2:0] RST_ST = 3'h0;
   localparam logic [7:0] FN_LATCH1 = 8'h20;
   localparam logic [7:0] FN_LATCH2 = 8'h21;
   localparam logic [7:0] FN_HOME_NO = 8'h22;
   localparam logic [7:0] FN_HOME_NC = 8'ha2;
   localparam logic [7:0] FN_NC = 8'h80;
   localparam logic [7:0] FN_SCTRL1 = 8'h20;
   localparam logic [7:0] FN_SCTRL3 = 8'h22;
   localparam logic [7:0] FN_RUN = 8'h01;
   localparam logic [10:0][7:0] FN_FORBID = {8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                                             8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c};
   localparam int LATCH1_PIN = 3;
   localparam int LATCH2_PIN = 4;
   localparam int ALARM_OUT = 2;
   localparam int CLK_NS = 50;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = (MS_NS + CLK_NS - 1) / CLK_NS;
endpackage
